//--- hdl/latency_decode.v
// Decodes feature fields into latency and recovery counts.
// Assumes the stored feature registers as inputs from the same clock.
`timescale 1ns/100ps
module latency_decode (
	input  wire [3:0] latency_code,
	input  wire       set_b,
	input  wire [2:0] recovery_code,
	input  wire       recovery_extend,
	output reg  [4:0] read_latency,
	output reg  [4:0] write_latency,
	output reg  [4:0] write_recovery_count,
	output reg        code_valid
);

	always @* begin
		code_valid    = 1'b1;
		read_latency  = 5'h0A;
		write_latency = 5'h06;
		case (latency_code)
		4'h1: begin read_latency = 5'h03; write_latency = 5'h01; end
		4'h4: begin read_latency = 5'h06; write_latency = 5'h03; end
		4'h6: begin read_latency = 5'h08; write_latency = 5'h04; end
		4'h7: begin read_latency = 5'h09; write_latency = 5'h05; end
		4'h8: begin read_latency = 5'h0A; write_latency = set_b ? 5'h08 : 5'h06; end
		4'h9: begin read_latency = 5'h0B; write_latency = set_b ? 5'h09 : 5'h06; end
		4'hA: begin read_latency = 5'h0C; write_latency = set_b ? 5'h09 : 5'h06; end
		4'hC: begin read_latency = 5'h0E; write_latency = set_b ? 5'h0B : 5'h08; end
		4'hE: begin read_latency = 5'h10; write_latency = set_b ? 5'h0D : 5'h08; end
		default: code_valid = 1'b0;
		endcase
	end

	always @* begin
		write_recovery_count = 5'h0A;
		if (!recovery_extend) begin
			case (recovery_code)
			3'h1: write_recovery_count = 5'h03;
			3'h4: write_recovery_count = 5'h06;
			3'h6: write_recovery_count = 5'h08;
			3'h7: write_recovery_count = 5'h09;
			default: write_recovery_count = 5'h09;
			endcase
		end else begin
			case (recovery_code)
			3'h0: write_recovery_count = 5'h0A;
			3'h1: write_recovery_count = 5'h0B;
			3'h2: write_recovery_count = 5'h0C;
			3'h4: write_recovery_count = 5'h0E;
			3'h6: write_recovery_count = 5'h10;
			default: write_recovery_count = 5'h0A;
			endcase
		end
	end

endmodule // latency_decode

//--- hdl/mode_reg_defines.vh
// Constants of the mode register bank: addresses, field positions, defaults, timing.
// Assumes inclusion by bare name from the bank's design files.
`ifndef MODE_REG_DEFINES_VH
`define MODE_REG_DEFINES_VH

`define ADDR_DEVICE_INFO       8'h00
`define ADDR_FEATURE_ONE       8'h01
`define ADDR_FEATURE_TWO       8'h02
`define ADDR_IO_CONFIG_ONE     8'h03
`define ADDR_REFRESH_RATE      8'h04
`define ADDR_MAKER_IDENTITY    8'h05
`define ADDR_DIE_REV_ONE       8'h06
`define ADDR_DIE_REV_TWO       8'h07
`define ADDR_GEOMETRY_INFO     8'h08
`define ADDR_VENDOR_TEST       8'h09
`define ADDR_IMPEDANCE_CAL     8'h0A
`define ADDR_TERMINATION       8'h0B
`define ADDR_BANK_MASK         8'h10
`define ADDR_SEGMENT_MASK      8'h11
`define ADDR_DQ_PATTERN_A      8'h20
`define ADDR_DQ_PATTERN_B      8'h28
`define ADDR_CA_TRAIN_ONE      8'h29
`define ADDR_CA_TRAIN_EXIT     8'h2A
`define ADDR_CA_TRAIN_TWO      8'h30
`define ADDR_SOFT_RESET        8'h3F

`define PAT_CA_TRAIN_ONE       8'hA4
`define PAT_CA_TRAIN_EXIT      8'hA8
`define PAT_CA_TRAIN_TWO       8'hC0

`define INFO_AUTO_INIT_BIT     0
`define INFO_SELFTEST_LSB      3
`define INFO_SET_B_BIT         6
`define INFO_LOW_LAT_BIT       7
`define INFO_MASK              8'hD9

`define FEAT1_BURST_LSB        0
`define FEAT1_RECOVERY_LSB     5
`define FEAT1_MASK             8'hE7
`define FEAT1_DEFAULT          8'h03
`define BURST_EIGHT_CODE       3'h3

`define FEAT2_LATENCY_LSB      0
`define FEAT2_EXTEND_BIT       4
`define FEAT2_SET_SEL_BIT      6
`define FEAT2_LEVEL_BIT        7
`define FEAT2_MASK             8'hDF
`define FEAT2_DEFAULT          8'h18

`define IO_CONFIG_MASK         8'h0F
`define IO_CONFIG_DEFAULT      8'h02
`define TERM_MASK              8'h07
`define TERM_DEFAULT           8'h00
`define MASK_DEFAULT           8'h00

`define CAL_INIT_CODE          8'hFF
`define CAL_LONG_CODE          8'hAB
`define CAL_SHORT_CODE         8'h56
`define CAL_RESET_CODE         8'hC3

`define SELFTEST_VDD_FLOAT     2'h1
`define SELFTEST_GND_SHORT     2'h2
`define SELFTEST_PASS          2'h3

`define CLK_PERIOD_NS          20
`define TERM_DELAY_NS          12
`define TERM_DELAY_CYCLES      ((`TERM_DELAY_NS / `CLK_PERIOD_NS) < 1 ? 1 : (`TERM_DELAY_NS / `CLK_PERIOD_NS))
`define INIT_TIME_CYCLES       64
`define CAL_INIT_CYCLES        50

`endif

//--- hdl/mode_register_bank.v
// Mode register bank: accepts register writes and reads from the command decoder.
// Assumes one-cycle write and read strobes with address and operand on the core clock.
`timescale 1ns/100ps
`include "mode_reg_defines.vh"
module mode_register_bank #(
	parameter INIT_CYCLES     = `INIT_TIME_CYCLES,
	parameter CAL_CYCLES      = `CAL_INIT_CYCLES,
	parameter [7:0] MAKER_ID  = 8'h5A, // Arbitrary value.
	parameter [7:0] REV_ONE   = 8'h11, // Arbitrary value.
	parameter [7:0] REV_TWO   = 8'h4E, // Arbitrary value.
	parameter [7:0] GEOMETRY  = 8'h1B,
	parameter [7:0] PATTERN_A = 8'h55,
	parameter [7:0] PATTERN_B = 8'h3C,
	parameter       LOW_LAT   = 1'b1,
	parameter       SET_B_OK  = 1'b1
) (
	input  wire       core_clk,
	input  wire       rst,
	input  wire       reg_write,
	input  wire       reg_read,
	input  wire [7:0] register_address,
	input  wire [7:0] operand_bits,
	input  wire [1:0] selftest_result,
	input  wire [7:0] refresh_rate_status,
	input  wire       low_power,
	input  wire [1:0] burst_start_column,
	input  wire [2:0] burst_beat,
	output reg  [7:0] read_data,
	output reg        read_valid,
	output reg        read_defined,
	output reg        strobe_toggle,
	output wire [2:0] burst_length,
	output wire [4:0] read_latency,
	output wire [4:0] write_latency,
	output wire [4:0] write_recovery_count,
	output wire       latency_code_valid,
	output wire       write_leveling,
	output reg  [1:0] ca_training_mode,
	output wire       factory_trim,
	output reg        cal_start,
	output reg  [7:0] cal_code,
	output wire [3:0] drive_strength,
	output wire [1:0] termination_resistance,
	output wire       termination_on,
	output wire [7:0] refresh_bank_mask,
	output wire [7:0] refresh_segment_mask,
	output wire [7:0] vendor_test,
	output wire [2:0] burst_address
);

	////////////////////////////////////////////////////////////////////////////////
	// Stored state.

	reg  [7:0] feature_one;
	reg  [7:0] feature_two;
	reg  [7:0] io_config_one;
	reg  [7:0] termination_feature;
	reg  [7:0] bank_mask;
	reg  [7:0] segment_mask;
	reg  [7:0] vendor_test_mode;
	reg        auto_init_status;
	reg  [1:0] cal_pin_selftest;
	reg  [7:0] init_count;
	reg  [7:0] cal_count;
	reg        cal_busy;
	reg  [7:0] next_read;
	reg        next_defined;
	wire       soft_reset;

	localparam [1:0] TRAIN_NONE = 2'h0;
	localparam [1:0] TRAIN_ONE  = 2'h1;
	localparam [1:0] TRAIN_TWO  = 2'h2;

	function is_readable;
		input [7:0] addr;
		begin
			case (addr)
			`ADDR_DEVICE_INFO, `ADDR_REFRESH_RATE, `ADDR_MAKER_IDENTITY,
			`ADDR_DIE_REV_ONE, `ADDR_DIE_REV_TWO, `ADDR_GEOMETRY_INFO,
			`ADDR_DQ_PATTERN_A, `ADDR_DQ_PATTERN_B: is_readable = 1'b1;
			default: is_readable = 1'b0;
			endcase
		end
	endfunction

	assign soft_reset = reg_write && register_address == `ADDR_SOFT_RESET;

	////////////////////////////////////////////////////////////////////////////////
	// Write path for configuration registers.

	always @(posedge core_clk) begin
		if (rst || soft_reset) begin
			feature_one         <= `FEAT1_DEFAULT;
			feature_two         <= `FEAT2_DEFAULT;
			io_config_one       <= `IO_CONFIG_DEFAULT;
			termination_feature <= `TERM_DEFAULT;
			bank_mask           <= `MASK_DEFAULT;
			segment_mask        <= `MASK_DEFAULT;
			vendor_test_mode    <= 8'h00;
		end else if (reg_write) begin
			case (register_address)
			`ADDR_FEATURE_ONE: feature_one <= operand_bits & `FEAT1_MASK;
			`ADDR_FEATURE_TWO: feature_two <= operand_bits & `FEAT2_MASK;
			`ADDR_IO_CONFIG_ONE: io_config_one <= operand_bits & `IO_CONFIG_MASK;
			`ADDR_TERMINATION: termination_feature <= operand_bits & `TERM_MASK;
			`ADDR_BANK_MASK: bank_mask <= operand_bits;
			`ADDR_SEGMENT_MASK: segment_mask <= operand_bits;
			`ADDR_VENDOR_TEST: vendor_test_mode <= operand_bits;
			default: ;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Command-address training mode.

	always @(posedge core_clk) begin
		if (rst || soft_reset) begin
			ca_training_mode <= TRAIN_NONE;
		end else if (reg_write) begin
			if (register_address == `ADDR_CA_TRAIN_ONE && operand_bits == `PAT_CA_TRAIN_ONE)
				ca_training_mode <= TRAIN_ONE;
			else if (register_address == `ADDR_CA_TRAIN_TWO && operand_bits == `PAT_CA_TRAIN_TWO)
				ca_training_mode <= TRAIN_TWO;
			else if (register_address == `ADDR_CA_TRAIN_EXIT && operand_bits == `PAT_CA_TRAIN_EXIT)
				ca_training_mode <= TRAIN_NONE;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Auto-initialization and calibration pin self-test.

	always @(posedge core_clk) begin
		if (rst || soft_reset) begin
			auto_init_status <= 1'b1;
			init_count       <= 8'h00;
		end else if (auto_init_status) begin
			if (init_count >= INIT_CYCLES - 1)
				auto_init_status <= 1'b0;
			else
				init_count <= init_count + 8'h01;
		end
	end

	assign factory_trim = cal_pin_selftest == `SELFTEST_VDD_FLOAT ||
	                      cal_pin_selftest == `SELFTEST_GND_SHORT;

	always @(posedge core_clk) begin
		if (rst) begin
			cal_pin_selftest <= 2'h0;
			cal_busy         <= 1'b0;
			cal_count        <= 8'h00;
			cal_start        <= 1'b0;
			cal_code         <= 8'h00;
		end else begin
			cal_start <= 1'b0;
			if (reg_write && register_address == `ADDR_IMPEDANCE_CAL && !factory_trim) begin
				case (operand_bits)
				`CAL_INIT_CODE, `CAL_LONG_CODE, `CAL_SHORT_CODE, `CAL_RESET_CODE: begin
					cal_start <= 1'b1;
					cal_code  <= operand_bits;
				end
				default: ;
				endcase
			end
			if (reg_write && register_address == `ADDR_IMPEDANCE_CAL &&
			    operand_bits == `CAL_INIT_CODE && !cal_busy) begin
				cal_busy  <= 1'b1;
				cal_count <= 8'h00;
			end else if (cal_busy) begin
				if (cal_count >= CAL_CYCLES - 1) begin
					cal_busy         <= 1'b0;
					cal_pin_selftest <= selftest_result;
				end else begin
					cal_count <= cal_count + 8'h01;
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Read path.

	always @* begin
		next_read    = 8'h00;
		next_defined = is_readable(register_address);
		case (register_address)
		`ADDR_DEVICE_INFO: begin
			next_read[`INFO_AUTO_INIT_BIT] = auto_init_status;
			next_read[`INFO_SELFTEST_LSB+1:`INFO_SELFTEST_LSB] = cal_pin_selftest;
			next_read[`INFO_SET_B_BIT] = SET_B_OK;
			next_read[`INFO_LOW_LAT_BIT] = LOW_LAT;
			next_read = next_read & `INFO_MASK;
		end
		`ADDR_REFRESH_RATE:   next_read = refresh_rate_status & 8'h87;
		`ADDR_MAKER_IDENTITY: next_read = MAKER_ID;
		`ADDR_DIE_REV_ONE:    next_read = REV_ONE;
		`ADDR_DIE_REV_TWO:    next_read = REV_TWO;
		`ADDR_GEOMETRY_INFO:  next_read = GEOMETRY;
		`ADDR_DQ_PATTERN_A:   next_read = PATTERN_A;
		`ADDR_DQ_PATTERN_B:   next_read = PATTERN_B;
		default:              next_read = 8'h00;
		endcase
	end

	always @(posedge core_clk) begin
		if (rst) begin
			read_data     <= 8'h00;
			read_valid    <= 1'b0;
			read_defined  <= 1'b0;
			strobe_toggle <= 1'b0;
		end else begin
			read_valid    <= reg_read;
			strobe_toggle <= reg_read;
			if (reg_read) begin
				read_data    <= next_read;
				read_defined <= next_defined;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Field outputs.

	assign burst_length   = feature_one[`FEAT1_BURST_LSB+2:`FEAT1_BURST_LSB];
	assign write_leveling = feature_two[`FEAT2_LEVEL_BIT];
	assign drive_strength = io_config_one[3:0];
	assign termination_resistance = termination_feature[1:0];
	assign refresh_bank_mask    = bank_mask;
	assign refresh_segment_mask = segment_mask;
	assign vendor_test          = vendor_test_mode;
	assign burst_address = {burst_start_column, 1'b0} + burst_beat;

	latency_decode u_latency (
		.latency_code         (feature_two[`FEAT2_LATENCY_LSB+3:`FEAT2_LATENCY_LSB]),
		.set_b                (feature_two[`FEAT2_SET_SEL_BIT]),
		.recovery_code        (feature_one[`FEAT1_RECOVERY_LSB+2:`FEAT1_RECOVERY_LSB]),
		.recovery_extend      (feature_two[`FEAT2_EXTEND_BIT]),
		.read_latency         (read_latency),
		.write_latency        (write_latency),
		.write_recovery_count (write_recovery_count),
		.code_valid           (latency_code_valid)
	);

	termination_ctrl u_termination (
		.core_clk           (core_clk),
		.rst                (rst),
		.term_wanted        (termination_feature[1:0] != 2'h0),
		.low_power          (low_power),
		.keep_in_power_down (termination_feature[2]),
		.termination_on     (termination_on)
	);

endmodule // mode_register_bank

//--- hdl/termination_ctrl.v
// Termination enable control around power-down and self-refresh states.
// Assumes low-power state levels from logic on the same clock.
`timescale 1ns/100ps
`include "mode_reg_defines.vh"
module termination_ctrl #(
	parameter DELAY_CYCLES = `TERM_DELAY_CYCLES
) (
	input  wire core_clk,
	input  wire rst,
	input  wire term_wanted,
	input  wire low_power,
	input  wire keep_in_power_down,
	output reg  termination_on
);

	reg [3:0] wait_count;
	wire      target;

	assign target = term_wanted & (~low_power | keep_in_power_down);

	// The enable follows the target after the fixed delay of one 20 ns clock cycle, longer than 12 ns.
	always @(posedge core_clk) begin
		if (rst) begin
			termination_on <= 1'b0;
			wait_count     <= 4'h0;
		end else if (target == termination_on) begin
			wait_count <= 4'h0;
		end else if (wait_count >= DELAY_CYCLES - 1) begin
			termination_on <= target;
			wait_count     <= 4'h0;
		end else begin
			wait_count <= wait_count + 4'h1;
		end
	end

endmodule // termination_ctrl

//--- testbench/mode_bank_properties.sv
// Concurrent checks on the mode register bank's ports.
// Assumes one core clock and a synchronous active-high reset.
`timescale 1ns/100ps
module mode_bank_properties (
	input wire       core_clk,
	input wire       rst,
	input wire       reg_write,
	input wire       reg_read,
	input wire [7:0] register_address,
	input wire [7:0] operand_bits,
	input wire [1:0] burst_start_column,
	input wire [2:0] burst_beat,
	input wire [7:0] read_data,
	input wire       read_valid,
	input wire       read_defined,
	input wire       strobe_toggle,
	input wire [4:0] read_latency,
	input wire [4:0] write_latency,
	input wire       write_leveling,
	input wire [1:0] ca_training_mode,
	input wire       factory_trim,
	input wire       cal_start,
	input wire [7:0] cal_code,
	input wire [2:0] burst_address
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (rst);
	sequence s_answer;
		read_valid && strobe_toggle;
	endsequence
	sequence s_ro_write;
		reg_write && register_address inside {8'h00, 8'h04, 8'h05, 8'h06, 8'h07, 8'h08};
	endsequence
	chk_read_answer: assert property (reg_read |=> s_answer)
		else $error("read not answered");
	chk_info_reserved: assert property (reg_read && register_address == 8'h00 |=> read_data[5] == 1'b0 && read_data[2:1] == 2'h0)
		else $error("reserved info bits not zero");
	chk_unreadable: assert property (reg_read && register_address == 8'h01 |=> s_answer and (!read_defined))
		else $error("write-only read handled wrongly");
	chk_set_b: assert property (reg_write && register_address == 8'h02 && operand_bits == 8'h58 |=> read_latency == 5'h0A && write_latency == 5'h08)
		else $error("set B latency wrong");
	chk_leveling_bit: assert property (reg_write && register_address == 8'h02 |=> write_leveling == $past(operand_bits[7]))
		else $error("leveling bit not applied");
	chk_training_one: assert property (reg_write && register_address == 8'h29 && operand_bits == 8'hA4 |=> ca_training_mode == 2'h1)
		else $error("training entry missed");
	chk_soft_reset: assert property (reg_write && register_address == 8'h3F |=> read_latency == 5'h0A && write_latency == 5'h06 && !write_leveling)
		else $error("soft reset defaults wrong");
	chk_burst_wrap: assert property (burst_address ==
		{2'(burst_start_column + burst_beat[2:1]), burst_beat[0]})
		else $error("burst address wrong");
	chk_init_cal: assert property (reg_write && register_address == 8'h0A && operand_bits == 8'hFF && !factory_trim |=> cal_start && cal_code == 8'hFF)
		else $error("init calibration not started");
	chk_cal_refused: assert property (reg_write && register_address == 8'h0A && !(operand_bits inside {8'hFF, 8'hAB, 8'h56, 8'hC3}) |=> !cal_start)
		else $error("reserved calibration code accepted");
	chk_ro_write: assert property (s_ro_write |=> $stable(read_latency) && $stable(write_latency) && $stable(write_leveling))
		else $error("read-only write changed state");
endmodule // mode_bank_properties

bind mode_register_bank mode_bank_properties chk (.core_clk, .rst, .reg_write, .reg_read,
	.register_address, .operand_bits, .burst_start_column, .burst_beat, .read_data, .read_valid,
	.read_defined, .strobe_toggle, .read_latency, .write_latency, .write_leveling,
	.ca_training_mode, .factory_trim, .cal_start, .cal_code, .burst_address);

//--- testbench/mode_reg_host.sv
// Controller model: issues mode register writes and reads one cycle after a request.
// Assumes requests from the bench on the core clock.
`timescale 1ns/100ps
module mode_reg_host (
	input  wire       core_clk,
	input  wire       rst,
	input  wire       cmd_go,
	input  wire       cmd_wr,
	input  wire [7:0] cmd_addr,
	input  wire [7:0] cmd_op,
	input  wire       set_b_ok,
	output reg        reg_write,
	output reg        reg_read,
	output reg  [7:0] register_address,
	output reg  [7:0] operand_bits
);
	reg [7:0] mask;
	reg       known;
	always @* begin
		known = 1'b1;
		case (cmd_addr)
		8'h02: mask = set_b_ok ? 8'hDF : 8'h9F;
		8'h03: mask = 8'h0F;
		8'h0B: mask = 8'h07;
		8'h00, 8'h01, 8'h04, 8'h05, 8'h06, 8'h07, 8'h08, 8'h09, 8'h0A, 8'h10, 8'h11: mask = 8'hFF;
		8'h20, 8'h28, 8'h29, 8'h2A, 8'h30, 8'h3F: mask = 8'hFF;
		default: begin
			mask = 8'hFF;
			known = 1'b0;
		end
		endcase
	end
	always @(posedge core_clk) begin
		reg_write <= !rst && cmd_go && cmd_wr && known;
		reg_read <= !rst && cmd_go && !cmd_wr;
		register_address <= cmd_go ? cmd_addr : ~register_address;
		if (cmd_addr == 8'h01 && cmd_go)
			operand_bits <= {cmd_op[7:5], 5'h03};
		else
			operand_bits <= cmd_go ? cmd_op & mask : ~operand_bits;
	end
endmodule // mode_reg_host

//--- testbench/test_mobile_dram_mode_registers.sv
// Self-checking bench for the mode register bank behind a controller model.
// Assumes a 50 MHz core clock and shortened init and calibration counts.
`timescale 1ns/100ps
module test_mobile_dram_mode_registers;
	reg         core_clk = 1'b0;
	reg         rst = 1'b1;
	reg         cmd_go = 1'b0;
	reg         cmd_wr = 1'b0;
	reg  [7:0]  cmd_addr = 8'h00;
	reg  [7:0]  cmd_op = 8'h00;
	reg         set_b_ok = 1'b0;
	reg  [1:0]  selftest_result = 2'h0;
	reg         low_power = 1'b0;
	reg  [1:0]  burst_start_column = 2'h0;
	reg  [2:0]  burst_beat = 3'h0;
	reg  [7:0]  refresh_status = 8'h00;
	wire        reg_write, reg_read, read_valid, read_defined, strobe_toggle, latency_code_valid;
	wire        write_leveling, factory_trim, cal_start, termination_on;
	wire [7:0]  register_address, operand_bits, read_data;
	wire [4:0]  read_latency, write_latency, write_recovery_count;
	wire [2:0]  burst_length, burst_address;
	wire [1:0]  ca_training_mode, termination_resistance;
	wire [7:0]  cal_code, refresh_bank_mask, refresh_segment_mask, vendor_test;
	wire [3:0]  drive_strength;
	integer     n_fail = 0;
	integer     num_checks = 0;
	integer     i;
	reg  [31:0] r;
	reg  [10:0] e;
	always #10 core_clk = ~core_clk;
	mode_reg_host host (.core_clk, .rst, .cmd_go, .cmd_wr, .cmd_addr, .cmd_op, .set_b_ok,
		.reg_write, .reg_read, .register_address, .operand_bits);
	mode_register_bank #(.INIT_CYCLES(16), .CAL_CYCLES(10)) uut (.core_clk, .rst, .reg_write,
		.reg_read, .register_address, .operand_bits, .selftest_result,
		.refresh_rate_status(refresh_status),
		.low_power, .burst_start_column, .burst_beat, .read_data, .read_valid, .read_defined,
		.strobe_toggle, .burst_length, .read_latency, .write_latency, .write_recovery_count,
		.latency_code_valid, .write_leveling, .ca_training_mode, .factory_trim, .cal_start,
		.cal_code, .drive_strength, .termination_resistance, .termination_on,
		.refresh_bank_mask, .refresh_segment_mask, .vendor_test, .burst_address);
	////////////////////////////////////////////////////////////////////////////////
	function [10:0] lat(input [3:0] c, input b);
		case (c)
		4'h1: lat = {1'b1, 5'h03, 5'h01};
		4'h4: lat = {1'b1, 5'h06, 5'h03};
		4'h6: lat = {1'b1, 5'h08, 5'h04};
		4'h7: lat = {1'b1, 5'h09, 5'h05};
		4'h8: lat = {1'b1, 5'h0A, b ? 5'h08 : 5'h06};
		4'h9: lat = {1'b1, 5'h0B, b ? 5'h09 : 5'h06};
		4'hA: lat = {1'b1, 5'h0C, b ? 5'h09 : 5'h06};
		4'hC: lat = {1'b1, 5'h0E, b ? 5'h0B : 5'h08};
		4'hE: lat = {1'b1, 5'h10, b ? 5'h0D : 5'h08};
		default: lat = 11'h000;
		endcase
	endfunction
	function [4:0] wrc(input [3:0] c);
		case (c)
		4'h1: wrc = 5'h03;
		4'h4: wrc = 5'h06;
		4'h6: wrc = 5'h08;
		4'h9: wrc = 5'h0B;
		4'hA: wrc = 5'h0C;
		4'hC: wrc = 5'h0E;
		4'hE: wrc = 5'h10;
		default: wrc = c[3] ? 5'h0A : 5'h09;
		endcase
	endfunction
	task chk(input string nm, input [7:0] got, input [7:0] exp);
		begin
			num_checks = num_checks + 1;
			if (got !== exp) begin
				n_fail = n_fail + 1;
				$display("Error %s expected %h seen %h", nm, exp, got);
			end
		end
	endtask
	task op(input wr, input [7:0] a, input [7:0] d);
		begin
			@(posedge core_clk);
			cmd_go <= 1'b1;
			cmd_wr <= wr;
			cmd_addr <= a;
			cmd_op <= d;
			@(posedge core_clk);
			cmd_go <= 1'b0;
			@(posedge core_clk);
			#1;
		end
	endtask
	task tally_and_finish;
		begin
			if (n_fail == 0 && num_checks > 0)
				$display("STATUS OK");
			else
				$display("STATUS NOT OK");
			$finish;
		end
	endtask
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		r = $urandom(32'hE1031C62);
		repeat (20) @(posedge core_clk);
		rst <= 1'b0;
		op(0, 8'h00, 8'h00);
		chk("info", read_data, 8'hC1);
		set_b_ok <= read_data[6];
		for (i = 0; i < 100 && read_data[0] !== 1'b0; i = i + 1)
			op(0, 8'h00, 8'h00);
		chk("info", read_data, 8'hC0);
		if (i == 100)
			tally_and_finish;
		chk("rl", read_latency, 5'h0A);
		chk("wl", write_latency, 5'h06);
		chk("recovery", write_recovery_count, 5'h0A);
		chk("burst", burst_length, 3'h3);
		chk("drive", drive_strength, 4'h2);
		chk("odt", termination_resistance, 2'h0);
		chk("bank_mask", refresh_bank_mask, 8'h00);
		chk("segment_mask", refresh_segment_mask, 8'h00);
		chk("vendor", vendor_test, 8'h00);
		for (i = 0; i < 32; i = i + 1) begin
			r = $urandom;
			op(1, 8'h02, {r[0], i[4], 2'h1, i[3:0]});
			e = lat(i[3:0], i[4]);
			chk("code_valid", latency_code_valid, e[10]);
			chk("rl", e[10] ? read_latency : 5'h00, e[9:5]);
			chk("wl", e[10] ? write_latency : 5'h00, e[4:0]);
			chk("leveling", write_leveling, r[0]);
		end
		op(1, 8'h02, 8'h58);
		chk("wl", write_latency, 5'h08);
		for (i = 0; i < 16; i = i + 1) begin
			op(1, 8'h02, {3'h0, i[3], 4'h8});
			op(1, 8'h01, {i[2:0], 5'h03});
			chk("recovery", write_recovery_count, wrc(i[3:0]));
		end
		op(1, 8'h00, r[15:8]);
		chk("rl", read_latency, 5'h0A);
		r = $urandom;
		op(1, 8'h03, r[7:0]);
		chk("drive", drive_strength, r[3:0]);
		op(1, 8'h10, r[15:8]);
		chk("bank_mask", refresh_bank_mask, r[15:8]);
		op(1, 8'h11, r[23:16]);
		chk("segment_mask", refresh_segment_mask, r[23:16]);
		op(1, 8'h09, r[31:24]);
		chk("vendor", vendor_test, r[31:24]);
		@(posedge core_clk) refresh_status <= r[7:0] ^ 8'h78;
		op(0, 8'h04, 8'h00);
		chk("refresh", read_data, (r[7:0] ^ 8'h78) & 8'h87);
		chk("valid", read_valid, 1'b1);
		op(0, 8'h01, 8'h00);
		chk("defined", read_defined, 1'b0);
		chk("strobe", strobe_toggle, 1'b1);
		op(1, 8'h0A, 8'h5A);
		chk("cal_start", cal_start, 1'b0);
		op(1, 8'h0A, 8'h56);
		chk("cal_start", cal_start, 1'b1);
		chk("cal_code", cal_code, 8'h56);
		op(1, 8'h0A, 8'hC3);
		chk("cal_code", cal_code, 8'hC3);
		for (i = 3; i > 0; i = i - 2) begin
			selftest_result <= i[1:0];
			op(1, 8'h0A, 8'hFF);
			chk("cal_start", cal_start, 1'b1);
			chk("cal_code", cal_code, 8'hFF);
			repeat (12) @(posedge core_clk);
			op(0, 8'h00, 8'h00);
			chk("selftest", read_data[4:3], i[1:0]);
		end
		chk("trim", factory_trim, 1'b1);
		op(1, 8'h0A, 8'hAB);
		chk("cal_start", cal_start, 1'b0);
		for (i = 0; i < 32; i = i + 1) begin
			@(posedge core_clk);
			burst_start_column <= i[4:3];
			burst_beat <= i[2:0];
			@(posedge core_clk);
			#1 chk("burst_addr", burst_address, ({i[4:3], 1'b0} + i[2:0]) & 3'h7);
		end
		op(1, 8'h0B, 8'h01);
		chk("odt", termination_resistance, 2'h1);
		repeat (2) @(posedge core_clk);
		#1 chk("term", termination_on, 1'b1);
		@(posedge core_clk) low_power <= 1'b1;
		repeat (2) @(posedge core_clk);
		#1 chk("term", termination_on, 1'b0);
		@(posedge core_clk) low_power <= 1'b0;
		repeat (2) @(posedge core_clk);
		#1 chk("term", termination_on, 1'b1);
		op(1, 8'h29, 8'hA4);
		chk("training", ca_training_mode, 2'h1);
		op(1, 8'h2A, 8'hA8);
		chk("training", ca_training_mode, 2'h0);
		op(1, 8'h30, 8'hC0);
		op(1, 8'h29, 8'hA5);
		chk("training", ca_training_mode, 2'h2);
		op(1, 8'h02, 8'hD1);
		op(1, 8'h3F, 8'h00);
		chk("training", ca_training_mode, 2'h0);
		chk("wl", write_latency, 5'h06);
		chk("leveling", write_leveling, 1'b0);
		tally_and_finish;
	end
endmodule // test_mobile_dram_mode_registers
